// ===== hdl/watchpoint_trace_debug_unit.v
// watchpoint, breakpoint and trace trigger logic of the coprocessor debug module
// assumes engine strobes are synchronous to pclk; tool reaches registers over apb
// Functional notes
// [RL1] status bit 5 halted, bit 4 low-power stopped, bit 0 single-step halt
// [RL2] status bit 3 shows non-recoverable signature miscompare
// [RL3] status bit 2 hardware breakpoint, bit 1 halt instruction breakpoint
// [RL4] watchpoint programmed to start and stop toggles the trace flag
// [RL5] start and stop watchpoints in same cycle toggle the trace flag
// [RL6] trigger flags ORed with trace mode bits drive trace enables
// [RL7] program start select 31-29: none, cmp1, cmp2, chanwr, hsr, link, mrl, tdl
// [RL8] program stop select 28-26 same coding, clears flag, 000 disables
// [RL9] data start 25-23 and stop 22-20 set or clear data flag
// [RL10] trigger bits 1,0 read flags; writing 1 clears, 0 keeps
// [RL11] four 2-bit window directions in 31-24: none, reads, writes, both
// [RL12] range bits 7-4 select inside (0) or outside (1) window match
// [RL13] reserved field encodings behave like the field reset value
// [RL14] breakpoint halts before instruction or before memory access
// [RL15] accesses during slot transition never produce breakpoints; code screens memory accesses only, fetch address matches still break
// [RL16] action 31-30: 00 off, 01 breakpoint, 10 reserved, 11 watchpoint
// [RL17] direction 29-28: read, write, any; 11 reserved
// [RL18] byte mask 23-20 excludes data bytes, bit 0 is lsb byte
// [RL19] size unit 19-18 reads 00 always
// [RL20] operand 17-15: off, write data, iaddr, data addr, data and addr
// [RL21] bit 14 routes occurrence to active-low event output
// [RL22] serviced channel must equal value 4-0 on mask 10-6 bits
// [RL23] trace mode 2-0: own, data, program trace enables
// [RL24] address match when equal on all mask-selected bits
// [RL25] data compare: 8-bit msbs, 24-bit lsbs, 32-bit all
// [RL26] watchpoint match gives one-cycle pulse, no halt
// [RL27] trigger flags reset-cleared; status flags follow live conditions
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "wtdu_consts.vh"

module watchpoint_trace_debug_unit (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire halted_in_debug_flag,
  input wire low_power_stopped_flag,
  input wire hardware_error_flag,
  input wire software_break_flag,
  input wire single_step_flag,
  input wire [4:0] serviced_channel,
  input wire slot_transition_phase,
  input wire ifetch_valid,
  input wire [15:0] ifetch_addr,
  input wire mem_valid,
  input wire mem_write,
  input wire [1:0] mem_size,
  input wire [13:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [4:0] misc_watch_pulse,
  output wire break_request,
  output wire [1:0] watch_pulse,
  output reg event_out_pin_n,
  output wire [`TM_WIDTH-1:0] trace_enable,
  output wire [3:0] window_read_enable,
  output wire [3:0] window_write_enable,
  output wire [3:0] window_outside
);

  // ==========================================================
  // register storage
  reg [31:0] trigger;
  reg [31:0] window_ctrl;
  // comparator registers live inside their own generate entries
  wire [63:0] cmp_ctrl_bus;
  wire [63:0] cmp_addr_bus;
  wire [63:0] cmp_data_bus;
  reg [31:0] next_prdata;
  reg [`TM_WIDTH-1:0] trace_type_enables;
  reg program_trigger_trace_flag;
  reg data_trigger_trace_flag;
  reg hw_break_seen;

  wire wr_access = psel & penable & pwrite;
  wire rd_setup = psel & ~penable;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================
  // comparators
  wire [1:0] cmp_hit;
  wire [1:0] cmp_break;
  wire [1:0] cmp_event;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_cmp
      wire [11:0] ctrl_ofs = (gi == 0) ? `OFS_CMP1_CTRL : `OFS_CMP2_CTRL;
      wire [11:0] addr_ofs = (gi == 0) ? `OFS_CMP1_ADDR : `OFS_CMP2_ADDR;
      wire [11:0] data_ofs = (gi == 0) ? `OFS_CMP1_DATA : `OFS_CMP2_DATA;
      reg [31:0] c;
      reg [31:0] a;
      reg [31:0] d;

      // size unit and reserved bits are never stored, so they read 0
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          c <= 32'h00000000;
          a <= 32'h00000000;
          d <= 32'h00000000;
        end
        else if (wr_access)
        begin
          if (paddr == ctrl_ofs)
            c <= pwdata & `CC_WMASK; // RL19
          if (paddr == addr_ofs)
            a <= pwdata;
          if (paddr == data_ofs)
            d <= pwdata;
        end
      end

      assign cmp_ctrl_bus[32 * gi +: 32] = c;
      assign cmp_addr_bus[32 * gi +: 32] = a;
      assign cmp_data_bus[32 * gi +: 32] = d;
      // reserved codes fall back to the reset (disabled/read) behaviour
      wire [1:0] act = (c[`CC_ACT] == 2'h2) ? 2'h0 : c[`CC_ACT]; // RL13 RL16
      wire [1:0] dir = (c[`CC_DIR] == 2'h3) ? `DIR_READ : c[`CC_DIR]; // RL13 RL17
      wire [2:0] op = c[`CC_OPER];
      wire chan_ok = ((c[`CC_CVAL] ^ serviced_channel) & c[`CC_CMSK]) == 5'h00; // RL22
      wire [13:0] am = a[31:18];
      wire iaddr_ok = ((a[15:2] ^ ifetch_addr[15:2]) & am) == 14'h0000; // RL24
      // data address ignores the two msbs; word addressable
      wire daddr_ok = ((a[13:2] ^ mem_addr[13:2]) & am[11:0]) == 12'h000; // RL24
      wire dir_ok = (dir == `DIR_ANY) | ((dir == `DIR_WRITE) == mem_write); // RL17
      reg [31:0] size_mask;
      always @*
      begin
        case (mem_size)
          `SZ_8: size_mask = 32'hFF000000; // RL25
          `SZ_24: size_mask = 32'h00FFFFFF; // RL25
          default: size_mask = 32'hFFFFFFFF; // RL25
        endcase
      end
      wire [31:0] byte_keep = {{8{~c[23]}}, {8{~c[22]}}, {8{~c[21]}}, {8{~c[20]}}}; // RL18
      wire data_ok = ((d ^ mem_wdata) & size_mask & byte_keep) == 32'h00000000;
      // slot-transition memory accesses are screened out here; fetches are not
      wire mem_q = mem_valid & ~slot_transition_phase; // RL15
      reg match;
      always @*
      begin
        case (op)
          `OP_DATA: match = mem_q & mem_write & data_ok; // RL20
          `OP_IADDR: match = ifetch_valid & iaddr_ok; // RL20
          `OP_DADDR: match = mem_q & dir_ok & daddr_ok; // RL20
          `OP_BOTH: match = mem_q & mem_write & data_ok & daddr_ok; // RL20
          default: match = 1'b0; // RL13
        endcase
      end
      assign cmp_hit[gi] = match & chan_ok & (act == `ACT_WATCH); // RL26
      assign cmp_break[gi] = match & chan_ok & (act == `ACT_BREAK);
      assign cmp_event[gi] = (cmp_hit[gi] | cmp_break[gi]) & c[`CC_EVT]; // RL21
    end
  endgenerate

  // combinational so the engine halts before the access or instruction
  assign break_request = |cmp_break; // RL14
  assign watch_pulse = cmp_hit; // RL26

  // ==========================================================
  // trace triggers
  wire [7:0] wp_src = {misc_watch_pulse[4:0], cmp_hit, 1'b0};
  wire [3:0] sel_pulse;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sel
      // each 3-bit select picks one source; code 000 is tied low
      wire [2:0] code = trigger[`TR_SEL_LSB + 3 * gi +: 3];
      assign sel_pulse[gi] = wp_src[code];
    end
  endgenerate
  wire p_start = sel_pulse[3]; // RL7
  wire p_stop = sel_pulse[2]; // RL8
  wire d_start = sel_pulse[1]; // RL9
  wire d_stop = sel_pulse[0]; // RL9

  wire wr_trig = wr_access & (paddr == `OFS_TRIGGER);
  wire p_clr = wr_trig & pwdata[`TR_PFLAG]; // RL10
  wire d_clr = wr_trig & pwdata[`TR_DFLAG]; // RL10
  wire [1:0] flag_start = {p_start, d_start};
  wire [1:0] flag_stop = {p_stop, d_stop};
  wire [1:0] flag_clr = {p_clr, d_clr};
  wire [1:0] flag_cur = {program_trigger_trace_flag, data_trigger_trace_flag};
  wire [1:0] next_flags;

  // index 1 is the program flag, index 0 the data flag
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_flag
      // a trigger in the clear cycle wins over the software clear
      wire kept = flag_cur[gi] & ~flag_clr[gi];
      reg nf;
      always @*
      begin
        if (flag_start[gi] & flag_stop[gi])
          nf = ~kept; // RL4 RL5
        else if (flag_start[gi])
          nf = 1'b1;
        else if (flag_stop[gi])
          nf = 1'b0;
        else
          nf = kept;
      end
      assign next_flags[gi] = nf;
    end
  endgenerate

  // trace enables: register mode bit, or trigger flag for data and program
  assign trace_enable[`TM_OWN] = trace_type_enables[`TM_OWN]; // RL23
  assign trace_enable[`TM_DATA] = trace_type_enables[`TM_DATA] | data_trigger_trace_flag; // RL6
  assign trace_enable[`TM_PROG] = trace_type_enables[`TM_PROG] | program_trigger_trace_flag; // RL6

  // ==========================================================
  // data trace windows
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_win
      wire [1:0] window_direction_select = window_ctrl[`WIN_DIR_LSB + 2 * gi +: 2];
      assign window_read_enable[gi] = window_direction_select[0]; // RL11
      assign window_write_enable[gi] = window_direction_select[1]; // RL11
      assign window_outside[gi] = window_ctrl[`WIN_RNG_LSB + gi]; // RL12
    end
  endgenerate

  // ==========================================================
  // trace trigger flags
  // only module reset, a stop trigger or a software clear lowers them
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      program_trigger_trace_flag <= 1'b0; // RL27
      data_trigger_trace_flag <= 1'b0; // RL27
    end
    else
    begin
      program_trigger_trace_flag <= next_flags[1];
      data_trigger_trace_flag <= next_flags[0];
    end
  end

  // ==========================================================
  // event pin and hardware break status
  // registered so the pin never glitches while comparators settle
  // misc sources have no event control here and never drive the pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_out_pin_n <= 1'b1;
    else
      event_out_pin_n <= ~(|cmp_event); // RL21
  end

  // hardware break stays only while the engine remains halted
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hw_break_seen <= 1'b0;
    else if (!halted_in_debug_flag)
      hw_break_seen <= break_request; // RL27
    else if (break_request)
      hw_break_seen <= 1'b1;
  end

  // ==========================================================
  // control register writes
  // trigger flag bits are not stored; a write there is a clear strobe
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trigger <= 32'h00000000;
      window_ctrl <= 32'h00000000;
      trace_type_enables <= 3'h0;
    end
    else if (wr_access)
    begin
      case (paddr)
        `OFS_TRIGGER: trigger <= pwdata & `TR_WMASK;
        `OFS_WINDOW: window_ctrl <= pwdata & `WIN_MASK;
        `OFS_TRACE_MODE: trace_type_enables <= pwdata[`TM_WIDTH-1:0];
        default: trigger <= trigger;
      endcase
    end
  end

  // ==========================================================
  // read mux
  wire [31:0] status_word = {26'h0,
    halted_in_debug_flag, // RL1
    low_power_stopped_flag, // RL1
    hardware_error_flag, // RL2
    hw_break_seen & halted_in_debug_flag, // RL3
    software_break_flag, // RL3
    single_step_flag}; // RL1

  // unmapped offsets read as zero
  always @*
  begin
    case (paddr)
      `OFS_STATUS: next_prdata = status_word;
      `OFS_TRIGGER: next_prdata = trigger
        | {30'h0, program_trigger_trace_flag, data_trigger_trace_flag}; // RL10
      `OFS_WINDOW: next_prdata = window_ctrl;
      `OFS_CMP1_CTRL: next_prdata = cmp_ctrl_bus[31:0];
      `OFS_CMP2_CTRL: next_prdata = cmp_ctrl_bus[63:32];
      `OFS_TRACE_MODE: next_prdata = {29'h0, trace_type_enables};
      `OFS_CMP1_ADDR: next_prdata = cmp_addr_bus[31:0];
      `OFS_CMP2_ADDR: next_prdata = cmp_addr_bus[63:32];
      `OFS_CMP1_DATA: next_prdata = cmp_data_bus[31:0];
      `OFS_CMP2_DATA: next_prdata = cmp_data_bus[63:32];
      default: next_prdata = 32'h00000000;
    endcase
  end

  // read data is captured in the setup cycle and stands through the access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
      prdata <= next_prdata;
  end

endmodule

`default_nettype wire

// ===== include/wtdu_consts.vh
// constants for the watchpoint / trace trigger debug unit
// assumes a 32-bit apb register bus and a single pclk domain
`ifndef WTDU_CONSTS_VH
`define WTDU_CONSTS_VH
// register byte offsets
`define OFS_STATUS 12'h000
`define OFS_TRIGGER 12'h004
`define OFS_WINDOW 12'h008
`define OFS_CMP1_CTRL 12'h00C
`define OFS_CMP2_CTRL 12'h010
`define OFS_TRACE_MODE 12'h014
`define OFS_CMP1_ADDR 12'h018
`define OFS_CMP2_ADDR 12'h01C
`define OFS_CMP1_DATA 12'h020
`define OFS_CMP2_DATA 12'h024
// status bit positions
`define ST_DEBUG 5
`define ST_STOP 4
`define ST_HWERR 3
`define ST_HWBRK 2
`define ST_SWBRK 1
`define ST_STEP 0
// trigger register fields
`define TR_PSTART 31:29
`define TR_PSTOP 28:26
`define TR_DSTART 25:23
`define TR_DSTOP 22:20
`define TR_WMASK 32'hFFF00000
`define TR_SEL_LSB 20
`define TR_PFLAG 1
`define TR_DFLAG 0
// window control fields
`define WIN_MASK 32'hFF0000F0
`define WIN_DIR_LSB 24
`define WIN_RNG_LSB 4
// comparator control fields
`define CC_ACT 31:30
`define CC_DIR 29:28
`define CC_BMASK 23:20
`define CC_OPER 17:15
`define CC_EVT 14
`define CC_CMSK 10:6
`define CC_CVAL 4:0
`define CC_WMASK 32'hF0F3C7DF
// encodings
`define ACT_BREAK 2'h1
`define ACT_WATCH 2'h3
`define DIR_READ 2'h0
`define DIR_WRITE 2'h1
`define DIR_ANY 2'h2
`define OP_DATA 3'h3
`define OP_IADDR 3'h4
`define OP_DADDR 3'h5
`define OP_BOTH 3'h7
`define SZ_8 2'h0
`define SZ_24 2'h1
`define SZ_32 2'h2
// trace mode bits
`define TM_OWN 0
`define TM_DATA 1
`define TM_PROG 2
`define TM_WIDTH 3
`endif

// ===== testbench/engine_model.sv
// engine model: presents fetches and shared memory accesses
// assumes break_request answers within the access cycle
`timescale 1ns/100ps
`default_nettype none
module engine_model (
  input wire logic pclk,
  input wire logic break_request,
  output logic halted_in_debug_flag,
  output logic ifetch_valid,
  output logic [15:0] ifetch_addr,
  output logic mem_valid,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [13:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic stopped
);
  initial
  begin
    {halted_in_debug_flag, ifetch_valid, mem_valid, mem_write, stopped} = 5'h00;
    {ifetch_addr, mem_size, mem_addr, mem_wdata} = 64'h0;
  end
  // ==========================================
  // one access; a hit halts before the access lands
  task automatic access(input logic f, input logic w, input logic [13:0] a);
    ifetch_valid <= f;
    ifetch_addr <= {2'h0, a};
    mem_valid <= !f;
    mem_write <= w;
    mem_size <= 2'h2;
    mem_addr <= a;
    mem_wdata <= 32'h5A5A00FF;
    @(posedge pclk);
    stopped <= break_request;
    halted_in_debug_flag <= halted_in_debug_flag | break_request;
    {ifetch_valid, mem_valid} <= 2'h0;
    // released lines flip so stale values never match
    ifetch_addr <= ~ifetch_addr;
    mem_addr <= ~a;
    mem_wdata <= ~mem_wdata;
    @(posedge pclk);
  endtask
  task automatic resume;
    halted_in_debug_flag <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_watchpoint_trace_debug_unit.sv
// bench: apb register sequences with engine accesses and trigger pulses
// assumes the unit, its checker and the engine model alongside
`timescale 1ns/100ps
`default_nettype none
`include "wtdu_consts.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED at %0t got %h expected %h", $time, a, e); end end
module test_watchpoint_trace_debug_unit;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, break_request, stopped;
  logic halted_in_debug_flag, low_power_stopped_flag, hardware_error_flag;
  logic software_break_flag, single_step_flag, slot_transition_phase, event_out_pin_n;
  logic ifetch_valid, mem_valid, mem_write;
  logic [1:0] mem_size, watch_pulse;
  logic [2:0] trace_enable;
  logic [3:0] window_read_enable, window_write_enable, window_outside;
  logic [4:0] serviced_channel, misc_watch_pulse;
  logic [11:0] paddr;
  logic [13:0] mem_addr;
  logic [15:0] ifetch_addr;
  logic [31:0] pwdata, prdata, mem_wdata, r;
  int errors = 0, checked = 0, cycles = 0;
  logic event_seen = 1'b0;
  // the event pin is low for one cycle only, so it is latched here
  always @(posedge pclk)
    event_seen <= event_seen | !event_out_pin_n;
  watchpoint_trace_debug_unit watchpoint_trace_debug_unit_i (.*);
  engine_model engine_model_i (.*);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // hang guard well above the fewer than one hundred cycles used
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      test_done;
    end
  end
  task automatic test_done;
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [4:0] p);
    misc_watch_pulse <= p;
    @(posedge pclk);
    misc_watch_pulse <= 5'h00;
    @(posedge pclk);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, misc_watch_pulse} = 0;
    {low_power_stopped_flag, hardware_error_flag, software_break_flag} = 3'h0;
    {single_step_flag, slot_transition_phase, serviced_channel} = 7'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    {low_power_stopped_flag, hardware_error_flag, software_break_flag} <= 3'h7;
    apb(0, `OFS_STATUS, 0);
    `CHK(r[5:0], 6'h1A)
    {low_power_stopped_flag, hardware_error_flag, software_break_flag} <= 3'h0;
    single_step_flag <= 1'b1;
    apb(0, `OFS_STATUS, 0);
    `CHK(r[5:0], 6'h01)
    single_step_flag <= 1'b0;
    apb(1, `OFS_CMP2_CTRL, 32'hFFFFFFFF);
    apb(0, `OFS_CMP2_CTRL, 0);
    `CHK(r, 32'hF0F3C7DF)
    apb(1, `OFS_WINDOW, 32'hFFFFFFFF);
    apb(0, `OFS_WINDOW, 0);
    `CHK(r, 32'hFF0000F0)
    `CHK(window_read_enable, 4'hF)
    `CHK(window_write_enable, 4'hF)
    `CHK(window_outside, 4'hF)
    apb(0, 12'h040, 0);
    `CHK(r, 32'h0)
    $display("registers test done");
    apb(1, `OFS_CMP1_ADDR, 32'hFFFC0120);
    apb(1, `OFS_CMP1_CTRL, 32'h5002C000);
    engine_model_i.access(0, 1, 14'h0123);
    `CHK(stopped, 1'b1)
    apb(0, `OFS_STATUS, 0);
    `CHK(r[5:0], 6'h24)
    `CHK(event_seen, 1'b1)
    engine_model_i.resume;
    engine_model_i.access(0, 1, 14'h0124);
    `CHK(stopped, 1'b0)
    engine_model_i.access(0, 0, 14'h0120);
    `CHK(stopped, 1'b0)
    slot_transition_phase <= 1'b1;
    engine_model_i.access(0, 1, 14'h0120);
    `CHK(stopped, 1'b0)
    slot_transition_phase <= 1'b0;
    $display("breakpoint test done");
    apb(1, `OFS_CMP2_ADDR, 32'hFFFC0040);
    apb(1, `OFS_CMP2_CTRL, 32'hE0020000);
    apb(1, `OFS_TRIGGER, 32'h49C00000);
    engine_model_i.access(1, 0, 14'h0040);
    `CHK(stopped, 1'b0)
    apb(0, `OFS_TRIGGER, 0);
    `CHK(r, 32'h49C00002)
    `CHK(trace_enable, 3'h4)
    engine_model_i.access(1, 0, 14'h0040);
    apb(0, `OFS_TRIGGER, 0);
    `CHK(r[1:0], 2'h0)
    pulse(5'h01);
    apb(0, `OFS_TRIGGER, 0);
    `CHK(r[1:0], 2'h1)
    pulse(5'h03);
    apb(0, `OFS_TRIGGER, 0);
    `CHK(r[1:0], 2'h0)
    pulse(5'h01);
    apb(1, `OFS_TRIGGER, 32'h49C00001);
    apb(0, `OFS_TRIGGER, 0);
    `CHK(r[1:0], 2'h0)
    apb(1, `OFS_TRACE_MODE, 32'h2);
    `CHK(trace_enable, 3'h2)
    $display("trigger test done");
    test_done;
  end
endmodule
bind watchpoint_trace_debug_unit wtdu_checker wtdu_checker_i (.*);
`default_nettype wire

// ===== testbench/wtdu_checker_assertions.sv
// checks on the debug unit's register, break and trace ports
// assumes binding to the unit; one pclk domain reset by presetn
`timescale 1ns/100ps
`default_nettype none
module wtdu_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic halted_in_debug_flag,
  input wire logic low_power_stopped_flag,
  input wire logic hardware_error_flag,
  input wire logic software_break_flag,
  input wire logic single_step_flag,
  input wire logic slot_transition_phase,
  input wire logic ifetch_valid,
  input wire logic mem_valid,
  input wire logic break_request,
  input wire logic [1:0] watch_pulse,
  input wire logic event_out_pin_n,
  input wire logic [2:0] trace_enable,
  input wire logic [3:0] window_read_enable,
  input wire logic [3:0] window_outside
);
  // ==========================================
  // port relations
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // read data is latched at the setup edge, hence the $past on live inputs
  property p_status;
    psel && penable && !pwrite && paddr == 12'h000 |-> prdata[5:0] ==
      {$past(halted_in_debug_flag), $past(low_power_stopped_flag),
      $past(hardware_error_flag), prdata[2] & $past(halted_in_debug_flag),
      $past(software_break_flag), $past(single_step_flag)};
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");
  property p_trace;
    psel && penable && !pwrite && paddr == 12'h004 |-> ($past(trace_enable[2]) || !prdata[1])
      && ($past(trace_enable[1]) || !prdata[0]);
  endproperty
  a_trace: assert property (p_trace) else $error("trace enable low");
  property p_slot;
    slot_transition_phase |-> !break_request;
  endproperty
  a_slot: assert property (p_slot) else $error("break in slot change");
  property p_idle;
    !mem_valid && !ifetch_valid |-> !break_request && watch_pulse == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("match without access");
  property p_event;
    $fell(event_out_pin_n) |-> $past(break_request || watch_pulse != 2'h0);
  endproperty
  a_event: assert property (p_event) else $error("event pin without match");
  property p_window;
    psel && penable && !pwrite && paddr == 12'h008 |-> $countones(window_outside) ==
      $countones(prdata[7:4]) && $countones(window_read_enable) ==
      $countones({prdata[30], prdata[28], prdata[26], prdata[24]});
  endproperty
  a_window: assert property (p_window) else $error("window outputs wrong");
  property p_size;
    psel && penable && !pwrite && (paddr == 12'h00C || paddr == 12'h010)
      |-> prdata[19:18] == 2'h0;
  endproperty
  a_size: assert property (p_size) else $error("size unit not zero");
  property p_reset;
    !$past(presetn) |-> trace_enable == 3'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("trace on after reset");
endmodule
`default_nettype wire
